// *** hw/sdpd_pkg.sv ***
// Purpose: shared constants and types for the dram power-down/clock model
// Assumes: 10 MHz core clock, command encoding cs_n,ras_n,cas_n,we_n
// Notes:   both ends of the link use these names
package sdpd_pkg;
   // ==========================================================
   // command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP   = 4'h7;
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_READ  = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_REF   = 4'h1;
   localparam logic [3:0] CMD_MRS   = 4'h0;
   // ==========================================================
   // timing
   localparam int CLK_NS        = 100;
   localparam int TCKE_NS       = 300;
   localparam int TCKE_CYC      = (TCKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int TXP_NS        = 200;
   localparam int TXP_CYC       = (TXP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TXARDS_NS     = 600;
   localparam int TXARDS_CYC    = (TXARDS_NS + CLK_NS - 1) / CLK_NS;
   localparam int OP_CYC        = 4;
   localparam int FREQ_WAIT_CYC = 2;
   localparam int MAX_REFI      = 8;
   localparam int TREFI_NS      = 7800;
   localparam int TREFI_CYC     = TREFI_NS / CLK_NS;
   localparam int PD_MAX_CYC    = MAX_REFI * TREFI_CYC;
   localparam int CNT_W         = 10;
   // ==========================================================
   // controller register map (wishbone word offsets)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int CTRL_PD   = 0;
   localparam int CTRL_FAST = 1;
   localparam int CTRL_OPEN = 2;
   localparam int CTRL_ODT  = 3;
   // ==========================================================
   typedef enum logic [3:0] {
      SDPD_UP   = 4'h1,
      SDPD_PPD  = 4'h2,
      SDPD_APDF = 4'h4,
      SDPD_APDS = 4'h8
   } sdpd_dev_t;
   typedef enum logic [3:0] {
      SDPD_C_RUN  = 4'h1,
      SDPD_C_DOWN = 4'h2,
      SDPD_C_EXIT = 4'h4,
      SDPD_C_HOLD = 4'h8
   } sdpd_ctl_t;
endpackage

// *** hw/sdpd_if.sv ***
// Purpose: pin bundle between memory controller and dram model
// Assumes: single clock, controller drives all pins
// Notes:   no two-way pins in this slice
`timescale 1ns/100ps
interface sdpd_if;
   logic       cke;
   logic       cs_n;
   logic       ras_n;
   logic       cas_n;
   logic       we_n;
   logic       odt;
   logic       ck_run;
   modport ctl (output cke, cs_n, ras_n, cas_n, we_n, odt, ck_run);
   modport dev (input  cke, cs_n, ras_n, cas_n, we_n, odt, ck_run);
endinterface

// *** hw/sdpd_dram.sv ***
// Purpose: dram-side power-down and command decode model
// Assumes: pins sampled on clk_i; controller keeps its timing
// Notes:   status outputs are registered
//
// Functional notes
// - cke low plus nop/deselect enters power-down
// - controller never drops cke mid-mrs/read/write
// - pending act/pre/ref completes before low power
// - controller enters power-down with dll locked
// - idle banks precharge, open row active
// - buffers off except clock, odt, cke
// - dll off except fast-exit active power-down
// - controller holds cke low, clock, odt valid
// - cke held at least tcke each level
// - power-down no longer than eight refis
// - cke high plus nop/deselect exits
// - controller waits exit latency before commands
// - async cke drop loses data; wait tdelay
// - restore clocks then reinitialize fully
// - spread band in range, 20-60khz modulation
// - locked dll allows 1%, else 0.5%
// - leaving band needs dll reset
// - frequency change only precharge power-down
// - odt and cke low during change
// - stable clocks, dll reset, odt off after
// - nop decodes and never aborts bursts
// - deselect ignores ras, cas, we
`timescale 1ns/100ps
module sdpd_dram (
   input  wire logic clk_i,
   input  wire logic rst_i,
   sdpd_if.dev       pin,
   input  wire logic mode_fast_i,
   output logic      pd_o,
   output logic      pd_active_o,
   output logic      dll_on_o,
   output logic      bufs_on_o,
   output logic      busy_o,
   output logic      bank_open_o,
   output logic      data_lost_o
);
   // ==========================================================
   // state
   typedef struct packed {
      sdpd_pkg::sdpd_dev_t st;
      logic                fast;
      logic                open;
      logic [3:0]          busy;
      logic                cke_d;
      logic                lost;
      logic                dll;
      logic                bufs;
   } sdpd_dst_t;
   sdpd_dst_t s_r, s_nxt;
   logic [3:0] cmd;
   logic       nop;
   always_comb begin
      cmd = {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n};
      // deselect ignores the strobes
      nop = pin.cs_n || (cmd == sdpd_pkg::CMD_NOP);
   end
   always_comb begin
      s_nxt = s_r;
      s_nxt.cke_d = pin.cke;
      // pending internal operation still counts down while down
      if (s_r.busy != 4'h0)
         s_nxt.busy = s_r.busy - 4'h1;
      unique case (s_r.st)
         sdpd_pkg::SDPD_UP: begin
            if (!pin.cke && s_r.cke_d && !nop)
               s_nxt.lost = 1'b1; // cke dropped with a real command
            else if (!pin.cke && nop) begin
               if (s_r.open)
                  s_nxt.st = s_r.fast ? sdpd_pkg::SDPD_APDF
                                      : sdpd_pkg::SDPD_APDS;
               else
                  s_nxt.st = sdpd_pkg::SDPD_PPD;
            end else if (pin.cke && !pin.cs_n) begin
               unique case (cmd)
                  sdpd_pkg::CMD_ACT: begin
                     s_nxt.open = 1'b1;
                     s_nxt.busy = 4'(sdpd_pkg::OP_CYC);
                  end
                  sdpd_pkg::CMD_PRE: begin
                     s_nxt.open = 1'b0;
                     s_nxt.busy = 4'(sdpd_pkg::OP_CYC);
                  end
                  sdpd_pkg::CMD_REF:
                     s_nxt.busy = 4'(sdpd_pkg::OP_CYC);
                  sdpd_pkg::CMD_MRS:
                     s_nxt.fast = mode_fast_i;
                  default: ;
               endcase
            end
         end
         default: begin
            // only cke and nop/deselect are watched while down
            if (pin.cke && nop)
               s_nxt.st = sdpd_pkg::SDPD_UP;
         end
      endcase
      // dll off in ppd and slow active power-down
      s_nxt.dll = (s_nxt.st == sdpd_pkg::SDPD_UP) ||
                  (s_nxt.st == sdpd_pkg::SDPD_APDF);
      s_nxt.bufs = (s_nxt.st == sdpd_pkg::SDPD_UP);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{st: sdpd_pkg::SDPD_UP, fast: 1'b0, open: 1'b0,
                  busy: 4'h0, cke_d: 1'b0, lost: 1'b0, dll: 1'b1,
                  bufs: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign pd_o        = (s_r.st != sdpd_pkg::SDPD_UP);
   assign pd_active_o = s_r.st[2] | s_r.st[3];
   assign dll_on_o    = s_r.dll;
   assign bufs_on_o   = s_r.bufs;
   assign busy_o      = (s_r.busy != 4'h0);
   assign bank_open_o = s_r.open;
   assign data_lost_o = s_r.lost;
endmodule

// *** hw/sdpd_ctl.sv ***
// Purpose: controller end: wishbone registers drive power-down on pins
// Assumes: software writes ctrl; ctl issues nop around cke edges
// Notes:   ack comes one cycle after the strobe
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module sdpd_ctl (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   sdpd_if.ctl              pin
);
   // ==========================================================
   // state
   typedef struct packed {
      sdpd_pkg::sdpd_ctl_t      st;
      logic [3:0]               ctrl;
      logic [sdpd_pkg::CNT_W-1:0] cnt;
      logic [15:0]              pdcnt;
      logic                     ack;
      logic [31:0]              dat;
      logic                     cke;
      logic                     odt;
      logic [3:0]               cmd;
      logic                     fast;
      logic                     open;
   } sdpd_cst_t;
   sdpd_cst_t s_r, s_nxt;
   logic acc;
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      // one-cycle commands; nop on every other edge
      s_nxt.cmd = sdpd_pkg::CMD_NOP;
      acc = wb_cyc_i && wb_stb_i && !s_r.ack;
      if (acc) begin
         s_nxt.ack = 1'b1;
         s_nxt.dat = 32'h0;
         if (wb_we_i && wb_adr_i == sdpd_pkg::REG_CTRL && wb_sel_i[0])
            s_nxt.ctrl = wb_dat_i[3:0];
         else if (!wb_we_i && wb_adr_i == sdpd_pkg::REG_CTRL)
            s_nxt.dat = {28'h0, s_r.ctrl};
         else if (!wb_we_i && wb_adr_i == sdpd_pkg::REG_STATUS)
            s_nxt.dat = {28'h0, s_r.st};
      end
      if (s_r.cnt != '0)
         s_nxt.cnt = s_r.cnt - 1'b1;
      unique case (s_r.st)
         sdpd_pkg::SDPD_C_RUN: begin
            s_nxt.odt = s_r.ctrl[sdpd_pkg::CTRL_ODT];
            // dll is never reset here, so entry is always with it locked
            // cke only drops at an edge with a nop
            if (s_r.cnt != '0) begin
               // last command's time still running: cke stays up
            end else if (s_r.ctrl[sdpd_pkg::CTRL_OPEN] != s_r.open) begin
               s_nxt.cmd  = s_r.ctrl[sdpd_pkg::CTRL_OPEN] ?
                            sdpd_pkg::CMD_ACT : sdpd_pkg::CMD_PRE;
               s_nxt.open = s_r.ctrl[sdpd_pkg::CTRL_OPEN];
               s_nxt.cnt  = sdpd_pkg::CNT_W'(sdpd_pkg::OP_CYC);
            end else if (s_r.ctrl[sdpd_pkg::CTRL_FAST] != s_r.fast) begin
               s_nxt.cmd  = sdpd_pkg::CMD_MRS;
               s_nxt.fast = s_r.ctrl[sdpd_pkg::CTRL_FAST];
               s_nxt.cnt  = sdpd_pkg::CNT_W'(sdpd_pkg::OP_CYC);
            end else if (s_r.ctrl[sdpd_pkg::CTRL_PD]) begin
               s_nxt.cke = 1'b0;
               s_nxt.st  = sdpd_pkg::SDPD_C_DOWN;
               s_nxt.cnt = sdpd_pkg::CNT_W'(sdpd_pkg::TCKE_CYC);
               s_nxt.pdcnt = 16'h0;
            end
         end
         sdpd_pkg::SDPD_C_DOWN: begin
            s_nxt.pdcnt = s_r.pdcnt + 16'h1;
            // exit on request or at eight refresh intervals
            if (s_r.cnt == '0 && (!s_r.ctrl[sdpd_pkg::CTRL_PD] ||
                32'(s_r.pdcnt) >= sdpd_pkg::PD_MAX_CYC - 1)) begin
               s_nxt.cke = 1'b1;
               s_nxt.st  = sdpd_pkg::SDPD_C_EXIT;
               s_nxt.cnt = sdpd_pkg::CNT_W'(sdpd_pkg::TXARDS_CYC);
            end
         end
         sdpd_pkg::SDPD_C_EXIT: begin
            if (s_r.cnt == '0) begin
               s_nxt.st  = sdpd_pkg::SDPD_C_HOLD;
               s_nxt.cnt = sdpd_pkg::CNT_W'(sdpd_pkg::TCKE_CYC);
            end
         end
         default: begin
            if (s_r.cnt == '0 && !s_r.ctrl[sdpd_pkg::CTRL_PD])
               s_nxt.st = sdpd_pkg::SDPD_C_RUN;
         end
      endcase
      if (s_nxt.st != sdpd_pkg::SDPD_C_RUN)
         s_nxt.odt = 1'b0; // termination off around power-down
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '{st: sdpd_pkg::SDPD_C_RUN, ctrl: 4'h0, cnt: '0,
                  pdcnt: 16'h0, ack: 1'b0, dat: 32'h0, cke: 1'b1,
                  odt: 1'b0, cmd: sdpd_pkg::CMD_NOP, fast: 1'b0,
                  open: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign wb_ack_o   = s_r.ack;
   assign wb_dat_o   = s_r.dat;
   assign pin.cke    = s_r.cke;
   assign pin.odt    = s_r.odt;
   assign pin.cs_n   = s_r.cmd[3];
   assign pin.ras_n  = s_r.cmd[2];
   assign pin.cas_n  = s_r.cmd[1];
   assign pin.we_n   = s_r.cmd[0];
   // clock kept stable, never spread nor retuned
   // no spreading or rate change
   assign pin.ck_run = 1'b1;
endmodule

// *** verif/sdpd_sva.sv ***
// Purpose: link and status checks between controller and dram ends
// Assumes: one clock, synchronous reset
// Notes:   watches the shared pins plus dram status
`timescale 1ns/100ps
module sdpd_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic odt,
   input wire logic pd_o,
   input wire logic pd_active_o,
   input wire logic dll_on_o,
   input wire logic bufs_on_o,
   input wire logic bank_open_o,
   input wire logic busy_o,
   input wire logic data_lost_o
);
   // ==========================================================
   // helpers
   logic       nd;
   logic [9:0] pd_cnt_r;
   // chip select high makes ras/cas/we irrelevant
   assign nd = cs_n | (ras_n & cas_n & we_n);
   always_ff @(posedge clk_i) begin
      pd_cnt_r <= (rst_i | !pd_o) ? 10'h0 : pd_cnt_r + 10'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // properties
   pd_entry_a: assert property (!cke && nd && !busy_o |=> pd_o)
      else $error("power-down not entered");
   pd_exit_a: assert property (cke && nd |=> !pd_o)
      else $error("power-down not left");
   entry_nop_a: assert property ($fell(cke) |-> nd)
      else $error("cke fell with a command");
   pd_class_a: assert property (pd_o |-> pd_active_o == bank_open_o)
      else $error("wrong power-down kind");
   bufs_off_a: assert property (pd_o |-> !bufs_on_o)
      else $error("buffers on in power-down");
   dll_off_a: assert property (pd_o && !pd_active_o |-> !dll_on_o)
      else $error("dll on in precharge power-down");
   low_hold_a: assert property ($fell(cke) |=> !cke [*2])
      else $error("cke low too short");
   high_hold_a: assert property ($rose(cke) |=> cke [*2])
      else $error("cke high too short");
   exit_wait_a: assert property ($rose(cke) |-> nd [*2])
      else $error("command inside exit latency");
   pd_len_a: assert property (pd_cnt_r <= sdpd_pkg::PD_MAX_CYC + 1)
      else $error("power-down too long");
   no_loss_a: assert property (!data_lost_o)
      else $error("array contents lost");
   odt_off_a: assert property (pd_o |-> !odt)
      else $error("termination on in power-down");
endmodule

// *** verif/tb_sdpd_power_down_clock_control.sv ***
// Purpose: drives the controller over wishbone, watches the dram end
// Assumes: 10 MHz clock, ack one cycle after strobe
// Notes:   read data is checked against queued notes
`timescale 1ns/100ps
module tb_sdram_power_down_clock_control;
   logic        clk_i, rst_i, cyc, stb, we, fast;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat;
   logic        ack, pd, pda, dll, bufs, busy, bopen, lost;
   int          n_errors, n_compared, seed, n;
   logic [31:0] exp_q[$];
   sdpd_if u_sdpd_if();
   sdpd_ctl u_sdpd_ctl(.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .pin(u_sdpd_if.ctl));
   sdpd_dram u_sdpd_dram(.clk_i, .rst_i, .pin(u_sdpd_if.dev),
      .mode_fast_i(fast), .pd_o(pd), .pd_active_o(pda), .dll_on_o(dll),
      .bufs_on_o(bufs), .busy_o(busy), .bank_open_o(bopen),
      .data_lost_o(lost));
   sdpd_sva u_sdpd_sva(.clk_i, .rst_i, .cke(u_sdpd_if.cke),
      .cs_n(u_sdpd_if.cs_n), .ras_n(u_sdpd_if.ras_n),
      .cas_n(u_sdpd_if.cas_n), .we_n(u_sdpd_if.we_n),
      .odt(u_sdpd_if.odt), .pd_o(pd),
      .pd_active_o(pda), .dll_on_o(dll), .bufs_on_o(bufs),
      .bank_open_o(bopen), .busy_o(busy), .data_lost_o(lost));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // ==========================================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'h1 | 4'($random(seed));
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      if (i == 50) begin
         n_errors++;
         conclude();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   // upper bits random: only bits 3:0 of lane 0 carry meaning
   task automatic ctl(input logic [3:0] v);
      wb(1'b1, sdpd_pkg::REG_CTRL, ($random(seed) & 32'hFFFFFFF0) | v);
   endtask
   task automatic wait_pd(input logic v);
      int i;
      for (i = 0; i < 2000; i++) begin
         @(posedge clk_i);
         if (pd === v) break;
      end
      if (i == 2000) begin
         n_errors++;
         conclude();
      end
   endtask
   // ==========================================================
   // monitor: read data against the oldest note
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         chk(rdat, exp_q.pop_front());
   end
   // ==========================================================
   // main sequence
   initial begin
      seed = 32'hBEAD;
      {n_errors, n_compared} = '0;
      {cyc, stb, we, fast, adr, sel, wdat} = '0;
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      exp_q.push_back(32'h1);
      wb(1'b0, sdpd_pkg::REG_STATUS, 32'h0);
      wb(1'b1, 4'h8, 32'hF);
      exp_q.push_back(32'h0);
      wb(1'b0, 4'h8, 32'h0);
      ctl(4'h1);
      wait_pd(1'b1);
      chk(pda, 1'b0);
      chk(dll, 1'b0);
      chk(bufs, 1'b0);
      exp_q.push_back(32'h2);
      wb(1'b0, sdpd_pkg::REG_STATUS, 32'h0);
      ctl(4'h0);
      wait_pd(1'b0);
      chk({bufs, dll}, 2'h3);
      for (n = 0; n < 2; n++) begin
         fast <= n[0];
         ctl({2'b01, n[0], 1'b0});
         repeat (10) @(posedge clk_i);
         chk(bopen, 1'b1);
         ctl({2'b01, n[0], 1'b1});
         wait_pd(1'b1);
         chk({pda, bufs}, 2'h2);
         chk(dll, n[0]);
         ctl({2'b00, n[0], 1'b0});
         wait_pd(1'b0);
         repeat (20) @(posedge clk_i);
      end
      ctl(4'h1);
      wait_pd(1'b1);
      n = 0;
      while (pd === 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      chk(n <= sdpd_pkg::PD_MAX_CYC + 1, 1'b1);
      ctl(4'h0);
      repeat (20) @(posedge clk_i);
      chk(lost, 1'b0);
      conclude();
   end
endmodule
